// [design/ssr_pkg.sv]
// constants shared by the start-stop serial receiver and its output store
// assumes a single 20 MHz clock; all timing is derived from it here
package ssr_pkg;

   // ==========================================================
   // clock and element timing
   localparam int CLOCK_HZ = 20_000_000;
   localparam int CYC_PER_US = CLOCK_HZ / 1_000_000;
   // unit interval per speed, in microseconds (7.42-unit frame basis)
   localparam int UNIT_US_60 = 22_460;
   localparam int UNIT_US_75 = 17_970;
   localparam int UNIT_US_100 = 13_480;
   localparam int UNIT_CYC_60_DEF = UNIT_US_60 * CYC_PER_US;
   localparam int UNIT_CYC_75_DEF = UNIT_US_75 * CYC_PER_US;
   localparam int UNIT_CYC_100_DEF = UNIT_US_100 * CYC_PER_US;
   // stop element length in hundredths of a unit: 7.42 - 6 and 11.00 - 9
   localparam int STOP_HUND_5 = 142;
   localparam int STOP_HUND_8 = 200;
   localparam int CNT_W = 21;

   // ==========================================================
   // code levels and sampling offset
   localparam logic [3:0] LEVELS_5 = 4'h5;
   localparam logic [3:0] LEVELS_8 = 4'h8;
   localparam int RANGE_LOG2 = 6;
   localparam logic [5:0] RANGE_CENTRE = 6'h20;

   // ==========================================================
   // reset values
   localparam logic [7:0] WORD_RESET = 8'h00;
   localparam logic [7:0] CONTACTS_ALL_CLOSED = 8'hFF;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      SSR_SPD_60 = 2'b00,
      SSR_SPD_75 = 2'b01,
      SSR_SPD_100 = 2'b10,
      SSR_SPD_RSVD = 2'b11
   } ssr_speed_t;

   typedef enum logic [1:0] {
      SSR_IDLE = 2'b00,
      SSR_START = 2'b01,
      SSR_DATA = 2'b10,
      SSR_STOP = 2'b11
   } ssr_state_t;

endpackage

// [design/ssr_store.sv]
// parallel output store of the start-stop receiver
// assumes word stays stable for at least two cycles after load
`timescale 1ns/10ps
`default_nettype none

module ssr_store
   import ssr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // transfer request from the selector
   input wire logic load,
   input wire logic [7:0] word,
   // contact outputs, 1 = contact closed (spacing)
   output logic [7:0] contact_closed,
   output logic word_strobe
);

   logic pending;

   // ==========================================================
   // wipe then load: a mark left from the last word must not survive
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         contact_closed <= CONTACTS_ALL_CLOSED;
         pending <= 1'b0;
         word_strobe <= 1'b0;
      end
      else if (load)
      begin
         contact_closed <= CONTACTS_ALL_CLOSED;
         pending <= 1'b1;
         word_strobe <= 1'b0;
      end
      else if (pending)
      begin
         contact_closed <= ~word;
         pending <= 1'b0;
         word_strobe <= 1'b1;
      end
      else
      begin
         word_strobe <= 1'b0;
      end
   end

endmodule // ssr_store

`default_nettype wire

// [design/ssr_receiver.sv]
// start-stop serial receiver: line sampling, serial to parallel, transfer
// assumes line and straps come from pins outside the clock domain
`timescale 1ns/10ps
`default_nettype none

// Function
// - current is marking one, none spacing zero
// - five or eight code levels selectable
// - frames of 7.42 or 11.00 units
// - speeds 60, 75, 100 words per minute
// - idle watches line, spacing edge starts cycle
// - sample each level in its slot, assemble word
// - after last level, trigger transfer to store
// - stop element ends cycle, line ignored meanwhile
// - store holds word until next transfer
// - store wipes old marks before loading
// - marking opens contact, spacing leaves closed
// - sampling instant shiftable by adjustable offset
module ssr_receiver
   import ssr_pkg::*;
#(
   parameter int UNIT_CYC_60 = UNIT_CYC_60_DEF,
   parameter int UNIT_CYC_75 = UNIT_CYC_75_DEF,
   parameter int UNIT_CYC_100 = UNIT_CYC_100_DEF
)(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // current-loop line, 1 = current flowing
   input wire logic line_current,
   // configuration straps
   input wire logic level8_sel,
   input wire logic [1:0] speed_sel,
   input wire logic [5:0] range_pos,
   // parallel contact outputs, 1 = contact closed
   output logic [7:0] contact_closed,
   output logic word_strobe,
   output logic busy
);

   // stop lengths per speed and level count
   localparam int STOP5_60 = UNIT_CYC_60 * STOP_HUND_5 / 100;
   localparam int STOP5_75 = UNIT_CYC_75 * STOP_HUND_5 / 100;
   localparam int STOP5_100 = UNIT_CYC_100 * STOP_HUND_5 / 100;
   localparam int STOP8_60 = UNIT_CYC_60 * STOP_HUND_8 / 100;
   localparam int STOP8_75 = UNIT_CYC_75 * STOP_HUND_8 / 100;
   localparam int STOP8_100 = UNIT_CYC_100 * STOP_HUND_8 / 100;

   // ==========================================================
   // synchronisers
   logic line_s1;
   logic line_s2;
   logic line_prev;
   logic [8:0] cfg_s1;
   logic [8:0] cfg_s2;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         line_s1 <= 1'b1;
         line_s2 <= 1'b1;
         line_prev <= 1'b1;
         cfg_s1 <= {1'b0, 2'b00, RANGE_CENTRE};
         cfg_s2 <= {1'b0, 2'b00, RANGE_CENTRE};
      end
      else
      begin
         line_s1 <= line_current;
         line_s2 <= line_s1;
         line_prev <= line_s2;
         cfg_s1 <= {level8_sel, speed_sel, range_pos};
         cfg_s2 <= cfg_s1;
      end
   end

   // ==========================================================
   // configuration decode
   wire logic cfg_lvl8 = cfg_s2[8];
   wire ssr_speed_t cfg_speed = ssr_speed_t'(cfg_s2[7:6]);
   wire logic [5:0] cfg_range = cfg_s2[5:0];
   wire logic line_mark = line_s2;
   wire logic start_edge = line_prev & ~line_mark;

   logic [CNT_W-1:0] unit_sel;
   logic [CNT_W-1:0] stop_sel;

   // reserved speed code falls back to the slowest rate
   function automatic logic [CNT_W-1:0] by_speed(input ssr_speed_t spd,
      input logic [CNT_W-1:0] v60, input logic [CNT_W-1:0] v75,
      input logic [CNT_W-1:0] v100);
      case (spd)
         SSR_SPD_75: by_speed = v75;
         SSR_SPD_100: by_speed = v100;
         default: by_speed = v60;
      endcase
   endfunction

   assign unit_sel = by_speed(cfg_speed, CNT_W'(UNIT_CYC_60), CNT_W'(UNIT_CYC_75),
                              CNT_W'(UNIT_CYC_100));
   assign stop_sel = cfg_lvl8 ?
      by_speed(cfg_speed, CNT_W'(STOP8_60), CNT_W'(STOP8_75), CNT_W'(STOP8_100)) :
      by_speed(cfg_speed, CNT_W'(STOP5_60), CNT_W'(STOP5_75), CNT_W'(STOP5_100));

   // range finder: sixty-four steps across the unit, centre at step 32
   wire logic [CNT_W-1:0] range_step = unit_sel >> RANGE_LOG2;
   wire logic [CNT_W+5:0] sample_prod = range_step * cfg_range;
   wire logic [CNT_W-1:0] sample_sel = sample_prod[CNT_W-1:0];

   // ==========================================================
   // frame state
   ssr_state_t state;
   ssr_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [3:0] elem;
   logic [3:0] next_elem;
   logic [7:0] word;
   logic [7:0] next_word;
   logic xfer;
   logic next_xfer;
   logic [3:0] levels_q;
   logic [CNT_W-1:0] unit_q;
   logic [CNT_W-1:0] stop_q;
   logic [CNT_W-1:0] sample_q;

   wire logic at_sample = (cnt == sample_q);
   wire logic at_unit_end = (cnt == unit_q - CNT_W'(1));
   wire logic at_stop_end = (cnt == stop_q - CNT_W'(1));
   wire logic last_level = (elem == levels_q);
   wire logic [2:0] bit_idx = 3'(elem - 4'h1);

   always_comb
   begin
      next_state = state;
      next_cnt = cnt + CNT_W'(1);
      next_elem = elem;
      next_word = word;
      next_xfer = 1'b0;
      case (state)
         SSR_IDLE:
         begin
            next_cnt = '0;
            if (start_edge)
            begin
               next_state = SSR_START;
               next_elem = 4'h0;
               next_word = WORD_RESET;
            end
         end
         SSR_START:
         begin
            // a start that is marking again at its sampling instant was noise
            if (at_sample && line_mark)
            begin
               next_state = SSR_IDLE;
            end
            else if (at_unit_end)
            begin
               next_state = SSR_DATA;
               next_cnt = '0;
               next_elem = 4'h1;
            end
         end
         SSR_DATA:
         begin
            if (at_sample)
            begin
               next_word[bit_idx] = line_mark;
               next_xfer = last_level;
            end
            if (at_unit_end)
            begin
               next_cnt = '0;
               if (last_level)
               begin
                  next_state = SSR_STOP;
               end
               else
               begin
                  next_elem = elem + 4'h1;
               end
            end
         end
         SSR_STOP:
         begin
            // line is not looked at until the stop time has run out
            if (at_stop_end)
            begin
               next_state = SSR_IDLE;
               next_cnt = '0;
            end
         end
         default:
         begin
            next_state = SSR_IDLE;
            next_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= SSR_IDLE;
         cnt <= '0;
         elem <= 4'h0;
         word <= WORD_RESET;
         xfer <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         elem <= next_elem;
         word <= next_word;
         xfer <= next_xfer;
      end
   end

   // straps are frozen for the whole frame so timing cannot shift mid-character
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         levels_q <= LEVELS_5;
         unit_q <= CNT_W'(UNIT_CYC_60);
         stop_q <= CNT_W'(STOP5_60);
         sample_q <= '0;
      end
      else if (state == SSR_IDLE && start_edge)
      begin
         levels_q <= cfg_lvl8 ? LEVELS_8 : LEVELS_5;
         unit_q <= unit_sel;
         stop_q <= stop_sel;
         sample_q <= sample_sel;
      end
   end

   assign busy = (state != SSR_IDLE);

   // ==========================================================
   // output store
   ssr_store u_store (
      .clock(clock),
      .arst_n(arst_n),
      .load(xfer),
      .word(word),
      .contact_closed(contact_closed),
      .word_strobe(word_strobe)
   );

endmodule // ssr_receiver

`default_nettype wire

// [sim/ssr_receiver_monitor.sv]
// port assertions for the start-stop receiver
// bound to every ssr_receiver instance
`timescale 1ns/10ps
`default_nettype none

module ssr_receiver_monitor
   import ssr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // line and straps
   input wire logic line_current,
   input wire logic level8_sel,
   input wire logic [1:0] speed_sel,
   input wire logic [5:0] range_pos,
   // outputs
   input wire logic [7:0] contact_closed,
   input wire logic word_strobe,
   input wire logic busy
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   // ==========================================================
   // level count of the frame in flight: straps pass two sync stages before the start latch
   logic [2:0] lvl8_hist;
   logic busy_d;
   logic frame_lvl8;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lvl8_hist <= 3'b000;
         busy_d <= 1'b0;
         frame_lvl8 <= 1'b0;
      end
      else
      begin
         lvl8_hist <= {lvl8_hist[1:0], level8_sel};
         busy_d <= busy;
         if (busy && !busy_d)
         begin
            frame_lvl8 <= lvl8_hist[2];
         end
      end
   end

   // ==========================================================
   // sequences
   sequence s_marking_run;
      line_current [*6];
   endsequence
   sequence s_wipe;
      $changed(contact_closed) && !word_strobe;
   endsequence

   // ==========================================================
   // properties
   a_reset_closed: assert property ($rose(arst_n) |-> contact_closed == 8'hFF && !busy)
      else $error("contacts not closed after reset");
   a_start_edge: assert property ($rose(busy) |-> !$past(line_current, 2) ||
      !$past(line_current, 3) || !$past(line_current, 4))
      else $error("cycle began without spacing");
   a_marking_quiet: assert property (s_marking_run |-> !$rose(busy))
      else $error("cycle began on marking line");
   a_wipe_load: assert property (s_wipe |=> word_strobe)
      else $error("wipe not followed by load");
   a_wipe_first: assert property (word_strobe |-> $past(contact_closed) == 8'hFF)
      else $error("load without prior wipe");
   a_hold_word: assert property ($changed(contact_closed) |-> word_strobe ||
      contact_closed == 8'hFF)
      else $error("stored word changed");
   a_strobe_busy: assert property (word_strobe |-> busy && $past(busy, 4))
      else $error("transfer outside a cycle");
   a_strobe_gap: assert property (word_strobe |=> !word_strobe [*8])
      else $error("strobe repeated");
   a_five_upper: assert property (word_strobe && !frame_lvl8 |->
      contact_closed[7:5] == 3'b111)
      else $error("unused levels not spacing");
endmodule // ssr_receiver_monitor

bind ssr_receiver ssr_receiver_monitor u_mon (.clock(clock), .arst_n(arst_n),
   .line_current(line_current), .level8_sel(level8_sel), .speed_sel(speed_sel),
   .range_pos(range_pos), .contact_closed(contact_closed), .word_strobe(word_strobe),
   .busy(busy));
`default_nettype wire

// [sim/ssr_sender.sv]
// remote start-stop sender on the current loop
// driven by the bench through send(); line changes 1 ns after a rising edge
`timescale 1ns/10ps
`default_nettype none

module ssr_sender
(
   // clock and line
   input wire logic clock,
   output logic line_current
);
   // loop idles marking between characters
   initial line_current = 1'b1;

   task automatic step(input logic lvl);
      @(posedge clock);
      #1 line_current = lvl;
   endtask

   // keep: cycles of each level shown true; the rest of the unit is inverted
   task automatic send(input logic [7:0] w, input int n, input int u,
      input int stop, input int keep);
      repeat (u) step(1'b0);
      for (int i = 0; i < n; i++)
         for (int c = 0; c < u; c++)
            step(c < keep ? w[i] : ~w[i]);
      repeat (stop) step(1'b1);
   endtask
endmodule // ssr_sender
`default_nettype wire

// [sim/test_start_stop_serial_receiver.sv]
// self-checking bench for the start-stop receiver
// short unit intervals keep frames near a thousand cycles
`timescale 1ns/10ps
`default_nettype none

module test_start_stop_serial_receiver
   import ssr_pkg::*;
;
   logic clock, arst_n, level8_sel, line_current, word_strobe, busy;
   logic [1:0] speed_sel;
   logic [5:0] range_pos;
   logic [7:0] contact_closed;
   int fails = 0;
   int checks_done = 0;

   ssr_receiver #(.UNIT_CYC_60(128), .UNIT_CYC_75(100), .UNIT_CYC_100(64)) u_dut (
      .clock(clock), .arst_n(arst_n), .line_current(line_current),
      .level8_sel(level8_sel), .speed_sel(speed_sel), .range_pos(range_pos),
      .contact_closed(contact_closed), .word_strobe(word_strobe), .busy(busy));
   ssr_sender u_tx (.clock(clock), .line_current(line_current));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // ==========================================================
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cfg(input logic l8, input logic [1:0] s, input logic [5:0] rp);
      @(posedge clock);
      #1;
      level8_sel = l8;
      speed_sel = s;
      range_pos = rp;
   endtask

   task automatic watch(input int n, output logic hit);
      hit = 1'b0;
      for (int i = 0; i < n && hit !== 1'b1; i++)
      begin
         @(negedge clock);
         hit = word_strobe;
      end
   endtask

   task automatic expect_word(input logic [7:0] exp);
      logic hit;
      watch(4000, hit);
      check({7'h00, hit}, 8'h01);
      check(contact_closed, exp);
   endtask

   // two spare stop cycles: a sender may run slightly slow, never fast
   task automatic frame(input logic [7:0] w, input int keep);
      int u;
      u = (speed_sel == 2'b01) ? 100 : (speed_sel == 2'b10) ? 64 : 128;
      u_tx.send(w, level8_sel ? 8 : 5, u, (level8_sel ? 2 * u : u * 142 / 100) + 2, keep);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_speeds;
      logic [7:0] w;
      for (int i = 0; i < 4; i++)
      begin
         w = 8'h0B + 8'(7 * i);
         cfg(1'b0, 2'(i), 6'h20);
         fork
            frame(w, 1000);
            expect_word({3'b111, ~w[4:0]});
         join
         repeat (6) @(negedge clock);
         check({7'h00, busy}, 8'h00);
      end
   endtask

   task automatic t_eight;
      cfg(1'b1, 2'b10, 6'h20);
      fork
         begin
            frame(8'hA5, 1000);
            frame(8'h3C, 1000);
         end
         begin
            expect_word(8'h5A);
            expect_word(8'hC3);
         end
      join
      repeat (300) @(negedge clock);
      check(contact_closed, 8'hC3);
   endtask

   task automatic t_offset_glitch;
      logic hit;
      cfg(1'b1, 2'b00, 6'h08);
      fork
         frame(8'h96, 32);
         expect_word(8'h69);
      join
      cfg(1'b0, 2'b00, 6'h20);
      u_tx.send(8'h00, 0, 10, 300, 0);
      watch(1000, hit);
      check({7'h00, hit}, 8'h00);
      check(contact_closed, 8'h69);
   endtask

   // a long spacing run inside the stop time must not open a new cycle
   task automatic t_stop_ignore;
      logic hit;
      cfg(1'b0, 2'b00, 6'h20);
      fork
         begin
            u_tx.send(8'h0D, 5, 128, 60, 1000);
            u_tx.send(8'h00, 0, 100, 300, 0);
         end
         expect_word(8'hF2);
      join
      watch(1000, hit);
      check({7'h00, hit}, 8'h00);
      check(contact_closed, 8'hF2);
   endtask

   // reset in mid-frame, then a clean frame must still be received
   task automatic t_reset_mid;
      cfg(1'b0, 2'b01, 6'h20);
      fork
         frame(8'h15, 1000);
         begin
            repeat (300) @(negedge clock);
            check({7'h00, busy}, 8'h01);
            @(posedge clock);
            #1 arst_n = 1'b0;
            repeat (2) @(negedge clock);
            check(contact_closed, 8'hFF);
            check({6'h00, word_strobe, busy}, 8'h00);
         end
      join
      @(posedge clock);
      #1 arst_n = 1'b1;
      repeat (4) @(negedge clock);
      check(contact_closed, 8'hFF);
      check({6'h00, word_strobe, busy}, 8'h00);
      fork
         frame(8'h0A, 1000);
         expect_word(8'hF5);
      join
   endtask

   initial
   begin
      arst_n = 1'b0;
      level8_sel = 1'b0;
      speed_sel = 2'b00;
      range_pos = 6'h20;
      repeat (5) @(posedge clock);
      #1 arst_n = 1'b1;
      repeat (4) @(negedge clock);
      check(contact_closed, 8'hFF);
      check({6'h00, word_strobe, busy}, 8'h00);
      t_speeds;
      t_eight;
      t_offset_glitch;
      t_stop_ignore;
      t_reset_mid;
      give_verdict;
   end

   initial
   begin
      repeat (40000) @(posedge clock);
      fails++;
      give_verdict;
   end
endmodule // test_start_stop_serial_receiver
`default_nettype wire
